// ==== hw/dsg_dif_eval.sv ====
// dsg_dif_eval: integrity status byte for one block
// assumes: computed guard and tags are supplied by the caller
`timescale 1ns/10ps
`default_nettype none
module dsg_dif_eval
    import dsg_pkg::*;
(
    // flags and fields
    input  wire logic [7:0]  sflags,
    input  wire logic [15:0] app_mask,
    input  wire logic [15:0] src_grd,
    input  wire logic [15:0] src_app,
    input  wire logic [31:0] src_ref,
    input  wire logic [15:0] calc_grd,
    input  wire logic [15:0] calc_app,
    input  wire logic [31:0] calc_ref,
    // result
    output logic [7:0]  code,
    output logic        fdet
);
    logic app_ones;
    logic ref_ones;
    logic all_ones;

    always_comb begin
        app_ones = &src_app;
        ref_ones = &src_ref;
        all_ones = app_ones && ref_ones && (&src_grd);
        fdet = (sflags[SF_ALLF] && all_ones)
            || (sflags[SF_APP_FDET] && app_ones)
            || (sflags[SF_AR_FDET] && app_ones && ref_ones);
        code = '0;
        // codes accumulate, so several mismatches show together
        if (!sflags[SF_GRD_DIS] && !fdet && calc_grd != src_grd) begin
            code = code | DIF_GRD_MIS;
        end
        if (app_mask != 16'hffff && !fdet && ((calc_app ^ src_app) & ~app_mask) != 16'h0000) begin
            code = code | DIF_APP_MIS;
        end
        if (!sflags[SF_REF_DIS] && !fdet && calc_ref != src_ref) begin
            code = code | DIF_REF_MIS;
        end
        if (sflags[SF_ALLF] && sflags[SF_ALLF_ERR] && all_ones) begin
            code = code | DIF_ALLF_ERR;
        end
    end
endmodule : dsg_dif_eval
`default_nettype wire

// ==== hw/dsg_pkg.sv ====
// dsg_pkg: constants and types of the data-integrity command block
// assumes: one 20 MHz clock domain, apb register access, 32-bit addresses
package dsg_pkg;

    // ==========================================================
    // operation codes
    localparam logic [7:0] OP_DIX_GEN   = 8'h17;
    localparam logic [7:0] OP_FLUSH     = 8'h20;
    localparam logic [7:0] OP_DIF_CHECK = 8'h12;

    // ==========================================================
    // completion status codes
    localparam logic [7:0] ST_NONE      = 8'h00;
    localparam logic [7:0] ST_SUCCESS   = 8'h01;
    localparam logic [7:0] ST_PAGE_FLT  = 8'h03;
    localparam logic [7:0] ST_DIF_ERR   = 8'h0a;
    localparam logic [7:0] ST_OVERLAP   = 8'h10;
    localparam logic [7:0] ST_BAD_OP    = 8'h11;

    // ==========================================================
    // integrity status byte codes
    localparam logic [7:0] DIF_GRD_MIS  = 8'h01;
    localparam logic [7:0] DIF_APP_MIS  = 8'h02;
    localparam logic [7:0] DIF_REF_MIS  = 8'h04;
    localparam logic [7:0] DIF_ALLF_ERR = 8'h08;

    // ==========================================================
    // source and destination flag bit positions
    localparam int SF_REF_DIS   = 6;
    localparam int SF_GRD_DIS   = 5;
    localparam int SF_AR_FDET   = 3;
    localparam int SF_APP_FDET  = 2;
    localparam int SF_ALLF      = 1;
    localparam int SF_ALLF_ERR  = 0;
    localparam int DF_REF_FIXED = 7;
    localparam int DF_APP_INC   = 4;

    // ==========================================================
    // register byte addresses
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_XFER    = 8'h04;
    localparam logic [7:0] REG_SRC     = 8'h08;
    localparam logic [7:0] REG_DST     = 8'h0c;
    localparam logic [7:0] REG_DIF     = 8'h10;
    localparam logic [7:0] REG_REFSEED = 8'h14;
    localparam logic [7:0] REG_APP     = 8'h18;
    localparam logic [7:0] REG_CHK0    = 8'h1c;
    localparam logic [7:0] REG_CHK1    = 8'h20;
    localparam logic [7:0] CR_W0       = 8'h40;
    localparam logic [7:0] CR_BYTES    = 8'h44;
    localparam logic [7:0] CR_FADDR    = 8'h48;
    localparam logic [7:0] CR_TAGS_LO  = 8'h58;
    localparam logic [7:0] CR_TAGS_HI  = 8'h5c;

    // ==========================================================
    // register field positions
    localparam int CTRL_START_BIT = 8;
    localparam int CTRL_BUSY_BIT  = 9;
    localparam int DIF_SF_LSB     = 0;
    localparam int DIF_DF_LSB     = 8;
    localparam int DIF_BS_LSB     = 16;
    localparam int HI_HALF_LSB    = 16;
    localparam int CR_STAT_LSB    = 0;
    localparam int CR_DIF_LSB     = 8;
    localparam int DIF_ENTRY_LG   = 3;

    // ==========================================================
    // block sizes
    localparam logic [31:0] BLK_512  = 32'h0000_0200;
    localparam logic [31:0] BLK_520  = 32'h0000_0208;
    localparam logic [31:0] BLK_4096 = 32'h0000_1000;
    localparam logic [31:0] BLK_4104 = 32'h0000_1008;

    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_COUNT = 3'h1,
        S_CHKOV = 3'h3,
        S_GUARD = 3'h2,
        S_WRITE = 3'h6,
        S_FLUSH = 3'h7,
        S_DONE  = 3'h5
    } dsg_state_t;

    function automatic logic [31:0] dsg_blk_bytes(input logic [1:0] sel);
        case (sel)
            2'h0:    dsg_blk_bytes = BLK_512;
            2'h1:    dsg_blk_bytes = BLK_520;
            2'h2:    dsg_blk_bytes = BLK_4096;
            default: dsg_blk_bytes = BLK_4104;
        endcase
    endfunction : dsg_blk_bytes

endpackage : dsg_pkg

// ==== hw/dsg_span.sv ====
// dsg_span: cache-line range covered by a byte region
// assumes: length nonzero when used; region does not wrap the address space
`timescale 1ns/10ps
`default_nettype none
module dsg_span #(
    parameter int LINE_LG = 6
) (
    // region
    input  wire logic [31:0] base,
    input  wire logic [31:0] len,
    // covered lines
    output logic [31:0] first_line,
    output logic [31:0] last_line
);
    logic [31:0] last_byte;

    always_comb begin
        last_byte  = base + len - 32'h1;
        // rounding both ends down catches partly covered lines
        first_line = (base >> LINE_LG) << LINE_LG;
        last_line  = (last_byte >> LINE_LG) << LINE_LG;
    end
endmodule : dsg_span
`default_nettype wire

// ==== hw/dsg_top.sv ====
// dsg_top: descriptor engine for integrity check, integrity generate and cache flush
// assumes: apb master, guard engine and memory port all on SYS_CLK
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - integrity status byte sits at completion record byte 1
// - status byte only set by check ops, with integrity error status
// - guard, app and ref mismatch codes are or-ed together
// - guard mismatch when checking enabled, no escape, values differ
// - app tag mismatch when mask not all ones, no escape, values differ
// - ref tag mismatch when checking enabled, no escape, values differ
// - all-ones error when detect and its error enable set and fields all ones
// - escape from all-ones, app-tag or app-plus-ref detect
// - generate writes only the integrity entries, never source data
// - block sizes 512, 520, 4096, 4104; total from transfer size
// - eight destination bytes per processed block
// - overlapping source and destination is an error
// - success writes final tags with success status
// - page fault writes updated tags with fault information
// - tags word at completion record byte 24
// - flush op flushes caches over destination range
// - any alignment and length; partly covered lines flushed too
module dsg_top
    import dsg_pkg::*;
#(
    parameter int LINE_LG = 6
) (
    // clock, reset, enable
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // guard engine
    output logic             GUARD_REQ,
    output logic      [31:0] GUARD_ADDR,
    output logic      [31:0] GUARD_LEN,
    input  wire logic        GUARD_VLD,
    input  wire logic [15:0] GUARD_VAL,
    // memory write and flush port
    output logic             MEM_REQ,
    output logic             MEM_FLUSH,
    output logic      [31:0] MEM_ADDR,
    output logic      [63:0] MEM_DATA,
    input  wire logic        MEM_READY,
    input  wire logic        MEM_FAULT,
    // operation state
    output logic             BUSY,
    output logic             DONE
);
    // ==========================================================
    // state
    typedef struct packed {
        dsg_state_t  st;
        logic [7:0]  op;
        logic [31:0] xfer, src, dst;
        logic [7:0]  sflags, dflags;
        logic [1:0]  bsel;
        logic [31:0] ref_seed;
        logic [15:0] app_seed, app_mask, chk_grd, chk_app;
        logic [31:0] chk_ref, rem, nblk, cur_src, cur_dst, ref_tag;
        logic [15:0] app_tag, guard;
        logic [7:0]  cr_st, cr_dif;
        logic [31:0] cr_bytes, cr_faddr, rdata;
        logic        perr;
    } dsg_regs_t;

    dsg_regs_t   q;
    dsg_regs_t   d;
    logic [31:0] bsz;
    logic [31:0] dlen;
    logic        ovl;
    logic        start;
    logic        setup;
    logic        wr;
    logic        busy;
    logic [7:0]  dif_code;
    logic        fdet;
    logic [31:0] first_line;
    logic [31:0] last_line;

    dsg_dif_eval u_eval (
        .sflags   (q.sflags),
        .app_mask (q.app_mask),
        .src_grd  (q.chk_grd),
        .src_app  (q.chk_app),
        .src_ref  (q.chk_ref),
        .calc_grd (GUARD_VAL),
        .calc_app (q.app_seed),
        .calc_ref (q.ref_seed),
        .code     (dif_code),
        .fdet     (fdet)
    );

    dsg_span #(.LINE_LG(LINE_LG)) u_span (
        .base       (q.dst),
        .len        (q.xfer),
        .first_line (first_line),
        .last_line  (last_line)
    );

    // ==========================================================
    // next state
    always_comb begin
        d     = q;
        start = 1'b0;
        busy  = (q.st != S_IDLE);
        bsz   = dsg_blk_bytes(q.bsel);
        dlen  = q.nblk << DIF_ENTRY_LG;
        ovl   = (q.nblk != 32'h0) && (q.dst < q.src + q.xfer)
             && (q.src < q.dst + dlen);
        setup = PSEL && !PENABLE;
        wr    = PSEL && PENABLE && PWRITE;

        // apb: decode in setup, reads answered from the flop next cycle
        if (setup) begin
            d.perr  = 1'b0;
            d.rdata = '0;
            case (PADDR)
                REG_CTRL: begin
                    d.rdata[7:0]           = q.op;
                    d.rdata[CTRL_BUSY_BIT] = busy;
                end
                REG_XFER:    d.rdata = q.xfer;
                REG_SRC:     d.rdata = q.src;
                REG_DST:     d.rdata = q.dst;
                REG_DIF: begin
                    d.rdata[DIF_SF_LSB +: 8] = q.sflags;
                    d.rdata[DIF_DF_LSB +: 8] = q.dflags;
                    d.rdata[DIF_BS_LSB +: 2] = q.bsel;
                end
                REG_REFSEED: d.rdata = q.ref_seed;
                REG_APP:     d.rdata = {q.app_mask, q.app_seed};
                REG_CHK0:    d.rdata = {q.chk_app, q.chk_grd};
                REG_CHK1:    d.rdata = q.chk_ref;
                CR_W0: begin
                    d.rdata[CR_STAT_LSB +: 8] = q.cr_st;
                    d.rdata[CR_DIF_LSB +: 8]  = q.cr_dif;
                end
                CR_BYTES:    d.rdata = q.cr_bytes;
                CR_FADDR:    d.rdata = q.cr_faddr;
                CR_TAGS_LO:  d.rdata = q.ref_tag;
                CR_TAGS_HI:  d.rdata = {q.app_tag, q.app_mask};
                default:     d.perr  = 1'b1;
            endcase
        end

        // settings are frozen while an operation runs
        if (wr && !busy) begin
            case (PADDR)
                REG_CTRL: begin
                    d.op  = PWDATA[7:0];
                    start = PWDATA[CTRL_START_BIT];
                end
                REG_XFER:    d.xfer = PWDATA;
                REG_SRC:     d.src = PWDATA;
                REG_DST:     d.dst = PWDATA;
                REG_DIF: begin
                    d.sflags = PWDATA[DIF_SF_LSB +: 8];
                    d.dflags = PWDATA[DIF_DF_LSB +: 8];
                    d.bsel   = PWDATA[DIF_BS_LSB +: 2];
                end
                REG_REFSEED: d.ref_seed = PWDATA;
                REG_APP: begin
                    d.app_seed = PWDATA[15:0];
                    d.app_mask = PWDATA[HI_HALF_LSB +: 16];
                end
                REG_CHK0: begin
                    d.chk_grd = PWDATA[15:0];
                    d.chk_app = PWDATA[HI_HALF_LSB +: 16];
                end
                REG_CHK1:    d.chk_ref = PWDATA;
                default: ;
            endcase
        end

        case (q.st)
            S_IDLE: begin
                if (start) begin
                    d.cr_st    = ST_NONE;
                    d.cr_dif   = '0;
                    d.cr_bytes = '0;
                    d.cr_faddr = '0;
                    d.ref_tag  = q.ref_seed;
                    d.app_tag  = q.app_seed;
                    d.cur_src  = q.src;
                    if (d.op == OP_DIX_GEN) begin
                        d.rem  = q.xfer;
                        d.nblk = '0;
                        d.st   = S_COUNT;
                    end else if (d.op == OP_FLUSH) begin
                        d.cur_dst = first_line;
                        if (q.xfer == 32'h0) begin
                            d.cr_st = ST_SUCCESS;
                            d.st    = S_DONE;
                        end else begin
                            d.st = S_FLUSH;
                        end
                    end else if (d.op == OP_DIF_CHECK) begin
                        d.st = S_GUARD;
                    end else begin
                        d.cr_st = ST_BAD_OP;
                        d.st    = S_DONE;
                    end
                end
            end
            S_COUNT: begin
                // a trailing partial block is left unprocessed
                if (q.rem >= bsz) begin
                    d.rem  = q.rem - bsz;
                    d.nblk = q.nblk + 32'h1;
                end else begin
                    d.st = S_CHKOV;
                end
            end
            S_CHKOV: begin
                d.cur_dst = q.dst;
                if (ovl) begin
                    d.cr_st = ST_OVERLAP;
                    d.st    = S_DONE;
                end else if (q.nblk == 32'h0) begin
                    d.cr_st = ST_SUCCESS;
                    d.st    = S_DONE;
                end else begin
                    d.st = S_GUARD;
                end
            end
            S_GUARD: begin
                if (GUARD_VLD) begin
                    d.guard = GUARD_VAL;
                    if (q.op == OP_DIF_CHECK) begin
                        d.cr_dif   = dif_code;
                        d.cr_st    = (dif_code != 8'h00) ? ST_DIF_ERR : ST_SUCCESS;
                        d.cr_bytes = bsz;
                        d.st       = S_DONE;
                    end else begin
                        d.st = S_WRITE;
                    end
                end
            end
            S_WRITE: begin
                if (MEM_FAULT) begin
                    // tags left at the values for the unfinished block
                    d.cr_st    = ST_PAGE_FLT;
                    d.cr_faddr = q.cur_dst;
                    d.st       = S_DONE;
                end else if (MEM_READY) begin
                    d.cur_dst  = q.cur_dst + (32'h1 << DIF_ENTRY_LG);
                    d.cur_src  = q.cur_src + bsz;
                    d.cr_bytes = q.cr_bytes + bsz;
                    d.nblk     = q.nblk - 32'h1;
                    d.ref_tag  = q.dflags[DF_REF_FIXED] ? q.ref_tag : q.ref_tag + 32'h1;
                    d.app_tag  = q.dflags[DF_APP_INC] ? q.app_tag + 16'h1 : q.app_tag;
                    if (q.nblk == 32'h1) begin
                        d.cr_st = ST_SUCCESS;
                        d.st    = S_DONE;
                    end else begin
                        d.st = S_GUARD;
                    end
                end
            end
            S_FLUSH: begin
                if (MEM_FAULT) begin
                    d.cr_st    = ST_PAGE_FLT;
                    d.cr_faddr = q.cur_dst;
                    d.st       = S_DONE;
                end else if (MEM_READY) begin
                    if (q.cur_dst == last_line) begin
                        d.cr_st    = ST_SUCCESS;
                        d.cr_bytes = q.xfer;
                        d.st       = S_DONE;
                    end else begin
                        d.cur_dst = q.cur_dst + (32'h1 << LINE_LG);
                    end
                end
            end
            S_DONE:  d.st = S_IDLE;
            default: d.st = S_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            q <= '0;
        end else if (CE) begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    always_comb begin
        PRDATA     = q.rdata;
        PREADY     = 1'b1;
        PSLVERR    = PSEL && PENABLE && q.perr;
        GUARD_REQ  = (q.st == S_GUARD);
        GUARD_ADDR = q.cur_src;
        GUARD_LEN  = bsz;
        MEM_REQ    = (q.st == S_WRITE) || (q.st == S_FLUSH);
        MEM_FLUSH  = (q.st == S_FLUSH);
        MEM_ADDR   = q.cur_dst;
        MEM_DATA   = {q.ref_tag, q.app_tag, q.guard};
        BUSY       = busy;
        DONE       = (q.st == S_DONE);
    end

    // ==========================================================
    // checks
    chk_status_offset: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && setup && !PWRITE && PADDR == CR_W0)
        |=> PRDATA[CR_DIF_LSB +: 8] == $past(q.cr_dif))
        else $error("status byte not at byte one");

    chk_dif_only_err: assert property (@(posedge SYS_CLK) disable iff (RST)
        (q.cr_dif != 8'h00) |-> (q.cr_st == ST_DIF_ERR && q.op == OP_DIF_CHECK))
        else $error("status byte set outside check error");

    chk_or_codes: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && q.st == S_GUARD && GUARD_VLD && q.op == OP_DIF_CHECK)
        |=> (q.cr_dif == $past(dif_code)) && (q.st == S_DONE))
        else $error("mismatch codes not combined");

    chk_guard_code: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && q.st == S_GUARD && GUARD_VLD && q.op == OP_DIF_CHECK
         && !q.sflags[SF_GRD_DIS] && !fdet && GUARD_VAL != q.chk_grd)
        |=> q.cr_dif[0])
        else $error("guard mismatch not reported");

    chk_allf_code: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && q.st == S_GUARD && GUARD_VLD && q.op == OP_DIF_CHECK
         && q.sflags[SF_ALLF] && q.sflags[SF_ALLF_ERR]
         && (&q.chk_app) && (&q.chk_ref) && (&q.chk_grd))
        |=> q.cr_dif[3] && !q.cr_dif[0])
        else $error("all-ones error not reported");

    chk_entry_step: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && q.st == S_WRITE && MEM_READY && !MEM_FAULT)
        |=> q.cur_dst == $past(q.cur_dst) + 32'h8)
        else $error("entry not eight bytes");

    chk_overlap_err: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && q.st == S_CHKOV && ovl)
        |=> (q.st == S_DONE && q.cr_st == ST_OVERLAP) ##1 (q.st == S_IDLE || !CE))
        else $error("overlap not refused");

    chk_fault_tags: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && q.st == S_WRITE && MEM_FAULT)
        |=> q.cr_st == ST_PAGE_FLT && q.ref_tag == $past(q.ref_tag)
            && q.cr_faddr == $past(q.cur_dst))
        else $error("fault record wrong");

    chk_flush_cover: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CE && q.st == S_FLUSH && MEM_READY && !MEM_FAULT && q.cur_dst != last_line)
        |=> q.st == S_FLUSH && q.cur_dst <= last_line)
        else $error("flush stopped early");
endmodule : dsg_top
`default_nettype wire

// ==== verification/dsg_far_model.sv ====
// dsg_far_model: guard engine and memory port seen from the block
// assumes: shares the block clock; slow adds wait cycles, fault fails writes
`timescale 1ns/10ps
`default_nettype none
module dsg_far_model (
    // control
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        fault,
    // guard side
    input  wire logic        g_req,
    output logic             g_vld,
    output logic      [15:0] g_val,
    // memory side
    input  wire logic        m_req,
    input  wire logic        m_flush,
    output logic             m_rdy,
    output logic             m_flt,
    output int               n_wr,
    output int               n_fl
);
    logic [1:0] dly = 2'h0;
    initial {g_vld, m_rdy, m_flt, g_val, n_wr, n_fl} = '0;
    // ==========================================================
    // answers; an idle guard bus scrambles so a stale value never matches
    always @(posedge clk) begin
        g_vld <= 1'b0;
        m_rdy <= 1'b0;
        m_flt <= 1'b0;
        g_val <= ~g_val;
        dly   <= dly + 2'h1;
        if (g_req && !g_vld && (!slow || dly == 2'h3)) begin
            g_vld <= 1'b1;
            g_val <= 16'h1234;
        end
        if (m_req && !m_rdy && !m_flt && (!slow || dly == 2'h3)) begin
            if (fault && !m_flush) m_flt <= 1'b1;
            else m_rdy <= 1'b1;
            if (m_flush) n_fl <= n_fl + 1;
            else n_wr <= n_wr + 1;
        end
    end
endmodule : dsg_far_model
`default_nettype wire

// ==== verification/tb.sv ====
// tb: apb-driven tests of check, generate and flush operations
// assumes: far-side model answers guard and memory requests
`timescale 1ns/10ps
`default_nettype none
module tb
    import dsg_pkg::*;
;
    logic        SYS_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic        slow = 0, fault = 0, rerr;
    logic [7:0]  PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, rd;
    logic        PREADY, PSLVERR, GUARD_REQ, GUARD_VLD, MEM_REQ, MEM_FLUSH;
    logic        MEM_READY, MEM_FAULT, DONE, BUSY, ce = 1;
    logic [15:0] GUARD_VAL;
    logic [31:0] GUARD_ADDR, GUARD_LEN, MEM_ADDR, ga, gl, la;
    logic [63:0] MEM_DATA, ld;
    int          n_wr, n_fl, w0, f0, err_total = 0, n_tests = 0, cyc = 0;
    logic [31:0] c0 [8] = '{32'h1111_0000, 32'hffff_ffff, 32'h5555_1234, 32'hffff_0000,
        32'h5555_0000, 32'h1111_1234, 32'hffff_0000, 32'hffff_ffff};
    logic [31:0] c1 [8] = '{32'h66, 32'hffff_ffff, 32'h77, 32'h66, 32'h66, 32'h66,
        32'hffff_ffff, 32'hffff_ffff};
    logic [7:0]  fl [8] = '{8'h00, 8'h03, 8'h00, 8'h04, 8'h20, 8'h40, 8'h08, 8'h01};
    logic [15:0] ew [8] = '{16'h070a, 16'h080a, 16'h0001, 16'h0001, 16'h040a, 16'h020a,
        16'h0001, 16'h070a};
    logic [31:0] bs [4] = '{32'd512, 32'd520, 32'd4096, 32'd4104};
    always #25 SYS_CLK = ~SYS_CLK;
    dsg_top DUT (.SYS_CLK(SYS_CLK), .RST(RST), .CE(ce), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .GUARD_REQ(GUARD_REQ), .GUARD_ADDR(GUARD_ADDR), .GUARD_LEN(GUARD_LEN),
        .GUARD_VLD(GUARD_VLD), .GUARD_VAL(GUARD_VAL), .MEM_REQ(MEM_REQ), .MEM_FLUSH(MEM_FLUSH),
        .MEM_ADDR(MEM_ADDR), .MEM_DATA(MEM_DATA), .MEM_READY(MEM_READY), .MEM_FAULT(MEM_FAULT),
        .BUSY(BUSY), .DONE(DONE));
    dsg_far_model far (.clk(SYS_CLK), .slow(slow), .fault(fault), .g_req(GUARD_REQ),
        .g_vld(GUARD_VLD), .g_val(GUARD_VAL), .m_req(MEM_REQ), .m_flush(MEM_FLUSH),
        .m_rdy(MEM_READY), .m_flt(MEM_FAULT), .n_wr(n_wr), .n_fl(n_fl));
    // ==========================================================
    // bus cycle, compare, operation
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do @(posedge SYS_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        rerr = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input logic [7:0] op, input logic [31:0] len, src, dst, dif);
        apb(1, REG_XFER, len);
        apb(1, REG_SRC, src);
        apb(1, REG_DST, dst);
        apb(1, REG_DIF, dif);
        w0 = n_wr;
        f0 = n_fl;
        apb(1, REG_CTRL, {23'h0, 1'b1, op});
        do @(posedge SYS_CLK); while (DONE !== 1'b1);
        chk({31'h0, BUSY}, 32'h1);
        apb(0, CR_W0, 0);
    endtask : run
    task automatic summarize();
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    always @(posedge SYS_CLK) begin
        cyc++;
        if (MEM_REQ && MEM_READY) {la, ld} <= {MEM_ADDR, MEM_DATA};
        if (GUARD_REQ && GUARD_VLD) {ga, gl} <= {GUARD_ADDR, GUARD_LEN};
        if (cyc == 30000) begin
            err_total++;
            summarize();
        end
    end
    // ==========================================================
    // scenarios
    initial begin
        repeat (20) @(posedge SYS_CLK);
        RST <= 1'b0;
        apb(1, REG_REFSEED, 32'h77);
        apb(1, REG_APP, 32'h5555);
        ce <= 1'b0;
        apb(1, REG_REFSEED, 32'h99);
        ce <= 1'b1;
        apb(0, REG_REFSEED, 0);
        chk(rd, 32'h77);
        for (int i = 0; i < 8; i++) begin
            slow <= i[0];
            apb(1, REG_CHK0, c0[i]);
            apb(1, REG_CHK1, c1[i]);
            run(OP_DIF_CHECK, 32'd512, 32'h0, 32'h800, {24'h0, fl[i]});
            chk({16'h0, rd[15:0]}, {16'h0, ew[i]});
        end
        for (int i = 0; i < 4; i++) begin
            run(OP_DIX_GEN, 2 * bs[i], 32'h10003, 32'h100, {14'h0, i[1:0], 16'h0});
            chk({24'h0, rd[7:0]}, 32'h01);
            chk(32'(n_wr - w0), 32'd2);
            chk(la, 32'h108);
            chk(ld[63:32], 32'h78);
            chk(ld[31:0], 32'h5555_1234);
            chk(ga, 32'h10003 + bs[i]);
            chk(gl, bs[i]);
            apb(0, CR_BYTES, 0);
            chk(rd, 2 * bs[i]);
            apb(0, CR_TAGS_LO, 0);
            chk(rd, 32'h79);
            apb(0, CR_TAGS_HI, 0);
            chk(rd, 32'h5555_0000);
        end
        fault <= 1'b1;
        run(OP_DIX_GEN, 32'd1024, 32'h10003, 32'h100, 0);
        chk({24'h0, rd[7:0]}, 32'h03);
        apb(0, CR_TAGS_LO, 0);
        chk(rd, 32'h77);
        apb(0, CR_FADDR, 0);
        chk(rd, 32'h100);
        fault <= 1'b0;
        run(OP_DIX_GEN, 32'd1024, 32'h100, 32'h100, 0);
        chk({24'h0, rd[7:0]}, 32'h10);
        run(OP_FLUSH, 32'd2, 32'h0, 32'h3f, 0);
        chk({24'h0, rd[7:0]}, 32'h01);
        chk(32'(n_fl - f0), 32'd2);
        chk(la, 32'h40);
        apb(0, 8'h80, 0);
        chk({31'h0, rerr}, 32'h1);
        chk(rd, 32'h0);
        summarize();
    end
endmodule : tb
`default_nettype wire
